// ---- cdpm_pkg.sv ----
// Package with constants and types for the clock distribution and power modes.
package cdpm_pkg;
    localparam int CDPM_NUM_SRC = 7;
    localparam int CDPM_SEL_W = 3;
    localparam int CDPM_DIV_W = 16;
    localparam int CDPM_NUM_DIG = 8;
    localparam int CDPM_NUM_ANA = 4;
    localparam int CDPM_NUM_DIV = CDPM_NUM_DIG + CDPM_NUM_ANA;
    localparam int CDPM_SUB_W = 8;
    localparam logic [15:0] CDPM_DIV_MIN = 16'h0002;
    localparam logic [15:0] CDPM_BUS_DIV_RST = 16'h0002;
    localparam logic [15:0] CDPM_DIV_RST = 16'h0002;
    localparam logic [7:0] CDPM_ACT_TPL_RST = 8'hFF;
    localparam logic [7:0] CDPM_ALT_TPL_RST = 8'hFE;
    localparam int CDPM_CPU_BIT = 0;
    localparam int CDPM_WAKE_W = 6;
    localparam int CDPM_WAKE_PIN = 1;
    localparam int CDPM_USB_HZ = 48_000_000;
    localparam int CDPM_USB_HALF_HZ = 24_000_000;

    typedef enum logic [1:0] {
        CDPM_ACTIVE = 2'h0,
        CDPM_ALT_ACTIVE = 2'h1,
        CDPM_SLEEP = 2'h3,
        CDPM_HIBERNATE = 2'h2
    } cdpm_mode_t;

    typedef enum logic [1:0] {
        CDPM_USB_DIRECT = 2'h0,
        CDPM_USB_DBL_OSC = 2'h1,
        CDPM_USB_DBL_IC = 2'h2,
        CDPM_USB_DBL_XTAL = 2'h3
    } cdpm_usb_src_t;
endpackage : cdpm_pkg

// ---- cdpm_divider.sv ----
// One clock divider: input selector, divide-by-N, resync and deglitch.
`timescale 1ns/1ps
module cdpm_divider
    import cdpm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] src_in,
    input wire logic [CDPM_SEL_W-1:0] sel,
    input wire logic [CDPM_DIV_W-1:0] ratio,
    input wire logic [CDPM_DIV_W-1:0] skew,
    input wire logic enable,
    output logic clk_out
);
    logic [2:0] sync_q, sync_d;
    logic [CDPM_SEL_W-1:0] sel_q, sel_d;
    logic [CDPM_DIV_W-1:0] ratio_q, ratio_d, cnt_q, cnt_d;
    logic [CDPM_DIV_W-1:0] skew_q, skew_d;
    logic div_q, div_d, out_q, out_d, rise;
    logic [CDPM_DIV_W-1:0] half;

    // Only the qualified source edges clock the divider counter.
    always_comb begin
        sync_d = {sync_q[1:0], src_in[sel_q]}; // R5 R7
        rise = sync_q[1] & ~sync_q[2];
        half = ratio_q >> 1;
        sel_d = sel_q;
        ratio_d = ratio_q;
        skew_d = skew_q;
        cnt_d = cnt_q;
        div_d = div_q;
        if (rise) begin
            if (cnt_q == ratio_q - 16'h0001) begin
                cnt_d = '0;
                div_d = 1'b0;
                // Settings load only at a period boundary.
                sel_d = sel; // R19
                ratio_d = (ratio < CDPM_DIV_MIN) ? CDPM_DIV_MIN : ratio; // R6
                skew_d = skew;
            end else begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q + 16'h0001 == half) begin
                    div_d = 1'b1; // R6
                end
            end
        end
        // A skewed phase shifts the high window later; analog use only.
        out_d = enable & div_q; // R6
        if (skew_q != '0) begin // R4
            out_d = enable & (((cnt_q + ratio_q - skew_q) % ratio_q) >= half);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_q <= '0;
            sel_q <= '0;
            ratio_q <= CDPM_DIV_RST;
            skew_q <= '0;
            cnt_q <= '0;
            div_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            sel_q <= sel_d;
            ratio_q <= ratio_d;
            skew_q <= skew_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            out_q <= out_d; // R7
        end
    end

    assign clk_out = out_q;

    a_div_boundary: assert property (@(posedge clk) disable iff (!nrst)
        !(rise && cnt_q == ratio_q - 16'h0001) |=> $stable(ratio_q)) // R19
        else $error("divider ratio changed mid-period");
    a_div_min: assert property (@(posedge clk) disable iff (!nrst)
        ratio_q >= CDPM_DIV_MIN) // R6
        else $error("divider ratio below two");
endmodule : cdpm_divider

// ---- cdpm_top.sv ----
// Central clock distribution and power-mode controller.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Seven sources selectable; system clock picked from the fastest one.
// R2 - 16-bit divider makes bus clock from system clock; CPU uses bus clock.
// R3 - Eight 16-bit digital dividers, each fed from any of seven sources.
// R4 - Four 16-bit analog dividers with adjustable skew.
// R5 - Each divider selects its input through an eight-input multiplexer.
// R6 - Ratios of two or more, about half duty cycle.
// R7 - Divider outputs resynchronised to system clock and deglitched.
// R8 - Digital divider outputs route back as inputs for chained division.
// R9 - Up to eight extra interconnect clocks feed the digital dividers.
// R10 - USB clock is 48 MHz direct or doubled 24 MHz source.
// R11 - USB logic crosses between bus and its own asynchronous clock.
// R12 - Four modes: active, alternate active, sleep, hibernate.
// R13 - In active modes each subsystem follows its template bit; in active the code also ANDs the CPU bit with cpu_q.
// R14 - Active entered by wakeup, reset or write; left on request.
// R15 - Alternate active only by write; any interrupt returns to active.
// R16 - Sleep gates most resources; only slow oscillators run; listed wakeups.
// R17 - Sleep keeps timewheel and real-time clock running.
// R18 - Hibernate stops all clocks; only pin interrupt unit wakes.
// R19 - Divider selection or ratio changes apply only at period boundary.
// R20 - Wakeup returns to active, re-enables CPU; active after boot.
module cdpm_top
    import cdpm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [CDPM_NUM_SRC-1:0] src_clk,
    input wire logic [CDPM_NUM_SRC-1:0] src_valid,
    input wire logic [CDPM_NUM_SRC*3-1:0] src_rank,
    input wire logic [CDPM_NUM_DIG-1:0] ic_clk,
    input wire logic [CDPM_DIV_W-1:0] bus_ratio,
    input wire logic [CDPM_NUM_DIV*CDPM_SEL_W-1:0] div_sel,
    input wire logic [CDPM_NUM_DIV*CDPM_DIV_W-1:0] div_ratio,
    input wire logic [CDPM_NUM_ANA*CDPM_DIV_W-1:0] ana_skew,
    input wire logic [1:0] usb_src,
    input wire logic usb_ic_48,
    output logic usb_clk_ok,
    input wire logic mode_wr,
    input wire logic [1:0] mode_req,
    input wire logic [CDPM_SUB_W-1:0] act_tpl,
    input wire logic [CDPM_SUB_W-1:0] alt_tpl,
    input wire logic cpu_off_req,
    input wire logic irq_any,
    input wire logic [CDPM_WAKE_W-1:0] wake_src,
    output logic [1:0] mode,
    output logic [CDPM_SUB_W-1:0] sub_en,
    output logic slow_clk_en,
    output logic timewheel_en,
    output logic [2:0] sys_sel,
    output logic bus_clk,
    output logic cpu_clk,
    output logic [CDPM_NUM_DIG-1:0] dig_clk,
    output logic [CDPM_NUM_ANA-1:0] ana_clk
);
    //////////////////////////////////////////////////////////////////////////
    // System clock source choice: highest rank among valid sources.
    logic [2:0] sys_sel_q, sys_sel_d;
    logic [2:0] best_rank;

    always_comb begin
        sys_sel_d = sys_sel_q;
        best_rank = 3'h0;
        for (int i = 0; i < CDPM_NUM_SRC; i++) begin
            if (src_valid[i] && src_rank[i*3 +: 3] >= best_rank) begin
                best_rank = src_rank[i*3 +: 3];
                sys_sel_d = 3'(i); // R1
            end
        end
    end

    // With no source running the old choice is kept rather than forced.
    a_sys_valid: assert property (@(posedge clk) disable iff (!nrst)
        (|src_valid) |-> src_valid[sys_sel_d]) // R1
        else $error("system clock picked from a stopped source");

    a_sys_hold: assert property (@(posedge clk) disable iff (!nrst)
        !(|src_valid) |=> sys_sel_q == $past(sys_sel_q)) // R1
        else $error("system clock choice moved with no source");

    //////////////////////////////////////////////////////////////////////////
    // Power mode state.
    cdpm_mode_t mode_q, mode_d;
    logic cpu_q, cpu_d;
    logic wake;

    always_comb begin
        mode_d = mode_q;
        cpu_d = cpu_q;
        unique case (mode_q)
            CDPM_ACTIVE, CDPM_ALT_ACTIVE: wake = irq_any; // R14 R15
            CDPM_SLEEP: wake = |wake_src; // R16
            CDPM_HIBERNATE: wake = wake_src[CDPM_WAKE_PIN]; // R18
        endcase
        if (cpu_off_req) begin
            cpu_d = 1'b0;
        end
        if (mode_wr) begin
            mode_d = cdpm_mode_t'(mode_req); // R14 R15
        end
        if (wake && mode_q != CDPM_ACTIVE) begin
            mode_d = CDPM_ACTIVE; // R20
            cpu_d = 1'b1;
        end else if (wake && !cpu_q) begin
            cpu_d = 1'b1; // R20
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= CDPM_ACTIVE; // R20
            cpu_q <= 1'b1;
            sys_sel_q <= 3'h0;
        end else begin
            mode_q <= mode_d; // R12
            cpu_q <= cpu_d;
            sys_sel_q <= sys_sel_d;
        end
    end

    logic clocks_on;
    always_comb begin
        unique case (mode_q)
            CDPM_ACTIVE: sub_en = act_tpl; // R13
            CDPM_ALT_ACTIVE: sub_en = alt_tpl; // R13 R15
            default: sub_en = '0; // R16 R18
        endcase
        if (mode_q == CDPM_ACTIVE) begin
            sub_en[CDPM_CPU_BIT] = act_tpl[CDPM_CPU_BIT] & cpu_q;
        end
        clocks_on = (mode_q == CDPM_ACTIVE) || (mode_q == CDPM_ALT_ACTIVE);
    end
    assign slow_clk_en = (mode_q != CDPM_HIBERNATE); // R16 R17
    assign timewheel_en = (mode_q != CDPM_HIBERNATE); // R17
    assign mode = mode_q;
    assign sys_sel = sys_sel_q;

    //////////////////////////////////////////////////////////////////////////
    // Reference tick at half the system clock.
    // The dividers count sampled rising edges, so a source can be seen at
    // most every other cycle. The bus divider therefore counts this tick,
    // and its period is twice its ratio in system clock cycles.
    logic sys_tick_q, sys_tick_d;

    always_comb begin
        sys_tick_d = ~sys_tick_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sys_tick_q <= 1'b0;
        end else begin
            sys_tick_q <= sys_tick_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus divider and the general dividers.
    // A constant level in a selector slot would never give an edge, so the
    // spare analog slot carries the reference tick instead.
    logic [7:0] base_src;
    logic [CDPM_NUM_DIG-1:0] dig_raw;
    assign base_src = {sys_tick_q, src_clk};

    cdpm_divider u_bus (
        .clk(clk), .nrst(nrst), .src_in({8{sys_tick_q}}), .sel(3'h0),
        .ratio(bus_ratio), .skew('0), .enable(clocks_on),
        .clk_out(bus_clk)); // R2
    assign cpu_clk = bus_clk & cpu_q & clocks_on; // R2

    genvar g;
    generate
        for (g = 0; g < CDPM_NUM_DIV; g++) begin : g_div
            logic [7:0] in_g;
            logic o_g;
            if (g < CDPM_NUM_DIG) begin : g_dig
                // Slot 7 takes the interconnect clock or the previous
                // divider, so two dividers chain to 32 bits.
                if (g == 0) begin : g_first
                    assign in_g = {ic_clk[0], src_clk}; // R9
                end else begin : g_rest
                    assign in_g = {ic_clk[g] | dig_raw[g-1], src_clk}; // R8 R9
                end
                assign dig_raw[g] = o_g;
                assign dig_clk[g] = o_g; // R3
            end else begin : g_ana
                assign in_g = base_src;
                assign ana_clk[g-CDPM_NUM_DIG] = o_g; // R4
            end
            cdpm_divider u_div (
                .clk(clk), .nrst(nrst), .src_in(in_g),
                .sel(div_sel[g*CDPM_SEL_W +: CDPM_SEL_W]), // R5
                .ratio(div_ratio[g*CDPM_DIV_W +: CDPM_DIV_W]),
                .skew(g < CDPM_NUM_DIG ? 16'h0000
                    : ana_skew[(g%CDPM_NUM_ANA)*CDPM_DIV_W +: CDPM_DIV_W]),
                .enable(clocks_on), .clk_out(o_g));
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // USB clock readiness, carried across with a two-stage synchroniser.
    logic [1:0] usb_sync_q, usb_sync_d;
    logic usb_raw;
    always_comb begin
        unique case (cdpm_usb_src_t'(usb_src))
            CDPM_USB_DIRECT: usb_raw = usb_ic_48; // R10
            default: usb_raw = src_valid[usb_src]; // R10
        endcase
        usb_sync_d = {usb_sync_q[0], usb_raw & clocks_on}; // R11
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb_sync_q <= '0;
        end else begin
            usb_sync_q <= usb_sync_d;
        end
    end
    assign usb_clk_ok = usb_sync_q[1];

    //////////////////////////////////////////////////////////////////////////
    a_mode_wake: assert property (@(posedge clk) disable iff (!nrst)
        (wake && mode_q != CDPM_ACTIVE) |=> mode_q == CDPM_ACTIVE) // R20
        else $error("wakeup did not return to active");
    a_hib_clocks: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_HIBERNATE |-> !cpu_clk && sub_en == '0) // R18
        else $error("clocks running in hibernate");
    a_sleep_slow: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_SLEEP |-> slow_clk_en && timewheel_en) // R16 R17
        else $error("slow clocks off in sleep");
    a_tpl_active: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_ALT_ACTIVE |-> sub_en == alt_tpl) // R13
        else $error("alternate template not applied");
    a_hib_pinwake: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q == CDPM_HIBERNATE && !mode_wr && !wake_src[CDPM_WAKE_PIN])
        |=> mode_q == CDPM_HIBERNATE) // R18
        else $error("hibernate left without pin interrupt");
    a_cpu_wake: assert property (@(posedge clk) disable iff (!nrst)
        (wake && !cpu_q) |=> cpu_q) // R20
        else $error("cpu not re-enabled on wakeup");
    c_sleep_wake: cover property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_SLEEP ##1 mode_q == CDPM_ACTIVE);
    c_hib_wake: cover property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_HIBERNATE ##1 mode_q == CDPM_ACTIVE);
    c_alt_irq: cover property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_ALT_ACTIVE ##1 mode_q == CDPM_ACTIVE);
    c_cpu_off: cover property (@(posedge clk) disable iff (!nrst)
        cpu_q ##1 !cpu_q);
    c_usb_ok: cover property (@(posedge clk) disable iff (!nrst)
        !usb_clk_ok ##1 usb_clk_ok);

    //////////////////////////////////////////////////////////////////////////
    // Mode entry and exit. Outside active, a wakeup beats a write in the same cycle, so the
    // write checks only hold when no wakeup is pending.
    a_mode_write: assert property (@(posedge clk) disable iff (!nrst)
        (mode_wr && !wake) |=> mode_q == $past(mode_req)) // R14 R15
        else $error("mode write not applied");

    a_alt_irq: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q == CDPM_ALT_ACTIVE && irq_any) |=> mode_q == CDPM_ACTIVE) // R15
        else $error("interrupt did not leave alternate active");

    a_alt_entry: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q != CDPM_ALT_ACTIVE && !mode_wr)
        |=> mode_q != CDPM_ALT_ACTIVE) // R15
        else $error("alternate active entered without a write");

    a_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q != CDPM_SLEEP && !mode_wr) |=> mode_q != CDPM_SLEEP) // R16
        else $error("sleep entered without a write");

    a_sleep_wake: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q == CDPM_SLEEP && |wake_src) |=> mode_q == CDPM_ACTIVE) // R16
        else $error("sleep wakeup source ignored");

    //////////////////////////////////////////////////////////////////////////
    // Gating of subsystems and clocks per mode.
    a_sleep_gate: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_SLEEP |-> sub_en == '0 && !cpu_clk) // R16
        else $error("resources left on in sleep");

    a_act_tpl: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_ACTIVE
        |-> sub_en[CDPM_SUB_W-1:1] == act_tpl[CDPM_SUB_W-1:1]) // R13
        else $error("active template not applied");

    a_cpu_gate: assert property (@(posedge clk) disable iff (!nrst)
        !cpu_q |-> !cpu_clk) // R2
        else $error("cpu clock running while cpu is off");

    a_hib_slow: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == CDPM_HIBERNATE |-> !slow_clk_en && !timewheel_en) // R18
        else $error("slow clocks running in hibernate");

    a_timewheel_on: assert property (@(posedge clk) disable iff (!nrst)
        mode_q != CDPM_HIBERNATE |-> timewheel_en) // R17
        else $error("timewheel stopped outside hibernate");

    a_slow_on: assert property (@(posedge clk) disable iff (!nrst)
        mode_q != CDPM_HIBERNATE |-> slow_clk_en) // R17
        else $error("slow oscillators stopped outside hibernate");

    // Divider outputs are registered, so they fall one cycle after gating.
    a_clk_stop: assert property (@(posedge clk) disable iff (!nrst)
        !clocks_on |=> !bus_clk && dig_clk == '0 && ana_clk == '0) // R16 R18
        else $error("divider clocks running in a low power mode");

    //////////////////////////////////////////////////////////////////////////
    // Processor enable.
    a_cpu_off: assert property (@(posedge clk) disable iff (!nrst)
        (cpu_off_req && !wake) |=> !cpu_q) // R20
        else $error("cpu did not switch itself off");

    a_cpu_keep: assert property (@(posedge clk) disable iff (!nrst)
        (!cpu_off_req && !wake) |=> cpu_q == $past(cpu_q)) // R20
        else $error("cpu enable changed without a cause");

    //////////////////////////////////////////////////////////////////////////
    // USB readiness crosses through two stages and follows the gating.
    a_usb_gate: assert property (@(posedge clk) disable iff (!nrst)
        !clocks_on |=> ##1 !usb_clk_ok) // R11
        else $error("usb clock reported ready in a low power mode");

    a_usb_lag: assert property (@(posedge clk) disable iff (!nrst)
        usb_clk_ok |-> $past(clocks_on, 2)) // R10 R11
        else $error("usb ready skipped the synchroniser");
endmodule : cdpm_top

// ---- cdpm_src_model.sv ----
// Model of the far-side clock sources and interconnect clocks.
`timescale 1ns/1ps
module cdpm_src_model (
    input wire logic clk,
    input wire logic [7:0] ic_en,
    output logic [6:0] src_clk,
    output logic [7:0] ic_clk
);
    int c = 0;
    initial src_clk = '0;
    initial ic_clk = '0;
    // Source i toggles every i+2 cycles, so all stay below clk/2.
    always @(posedge clk) begin
        c <= c + 1;
        for (int i = 0; i < 7; i++) begin
            if (c % (i + 2) == 0) src_clk[i] <= ~src_clk[i];
        end
        // A disabled interconnect clock stands low instead of freezing.
        for (int i = 0; i < 8; i++) begin
            ic_clk[i] <= ic_en[i] & ((c % 3 == 0) ? ~ic_clk[i] : ic_clk[i]);
        end
    end
endmodule : cdpm_src_model

// ---- tb_top.sv ----
// Self-checking testbench for the clock and power-mode controller.
`timescale 1ns/1ps
module tb_top;
    import cdpm_pkg::*;
    logic clk = 0;
    logic nrst = 0;
    logic [6:0] src_clk, src_valid;
    logic [20:0] src_rank;
    logic [7:0] ic_clk, ic_en, act_tpl, alt_tpl, sub_en, dig_clk;
    logic [15:0] bus_ratio;
    logic [35:0] div_sel;
    logic [191:0] div_ratio;
    logic [63:0] ana_skew;
    logic [1:0] usb_src, mode_req, mode;
    logic usb_ic_48, usb_clk_ok, mode_wr, cpu_off_req, irq_any;
    logic slow_clk_en, timewheel_en, bus_clk, cpu_clk;
    logic [5:0] wake_src;
    logic [2:0] sys_sel;
    logic [3:0] ana_clk;
    logic [12:0] clks;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int exp_mode, cpu_off, e, h, s, r, best;
    int ratios [5] = '{0, 1, 2, 3, 6};
    assign clks = {ana_clk, dig_clk, bus_clk};
    always #4 clk = ~clk;
    cdpm_src_model src_m (.clk, .ic_en, .src_clk, .ic_clk);
    cdpm_top uut (.clk, .nrst, .src_clk, .src_valid, .src_rank, .ic_clk,
        .bus_ratio, .div_sel, .div_ratio, .ana_skew, .usb_src, .usb_ic_48,
        .usb_clk_ok, .mode_wr, .mode_req, .act_tpl, .alt_tpl, .cpu_off_req,
        .irq_any, .wake_src, .mode, .sub_en, .slow_clk_en, .timewheel_en,
        .sys_sel, .bus_clk, .cpu_clk, .dig_clk, .ana_clk);
    ///////////////////////////////////////////////////////////////////////
    task results;
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // The run should take about 11000 cycles; nearly three times that means a hang.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    task chk(input string n, input logic [15:0] x, input logic [15:0] g,
        input int tol = 0);
        checked++;
        if ($isunknown(g) || (g > x ? g - x : x - g) > tol) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %0h got %0h", n, x, g);
        end
    endtask : chk
    task step;
        @(posedge clk);
        #1;
    endtask : step
    function logic [7:0] exp_sub();
        case (exp_mode)
            0: return act_tpl & ~8'(cpu_off);
            1: return alt_tpl;
            default: return 8'h00;
        endcase
    endfunction : exp_sub
    task chk_mode;
        chk("mode", 16'(exp_mode), mode);
        chk("sub_en", exp_sub(), sub_en);
    endtask : chk_mode
    task set_mode(input cdpm_mode_t m);
        mode_wr = 1;
        mode_req = m;
        step();
        mode_wr = 0;
        exp_mode = m;
        chk_mode();
        step();
    endtask : set_mode
    // Any wakeup wins in sleep, only the pin one in hibernate; irq only counts in the two active modes.
    task poke(input logic [5:0] w, input logic i);
        wake_src = w;
        irq_any = i;
        step();
        wake_src = '0;
        irq_any = 0;
        if ((exp_mode == 2) ? w[CDPM_WAKE_PIN] : (w != 0 || (i && exp_mode < 2)))
        begin
            exp_mode = 0;
            cpu_off = 0;
        end
        chk_mode();
        step();
    endtask : poke
    task cnt_edges(input int k, input int n);
        logic p;
        e = 0;
        h = 0;
        p = clks[k];
        repeat (n) begin
            step();
            if (clks[k] && !p) e++;
            h += int'(clks[k]);
            p = clks[k];
        end
    endtask : cnt_edges
    ///////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(13484));
        {src_valid, ic_en, usb_src, usb_ic_48, mode_wr, mode_req} = '1;
        {cpu_off_req, irq_any, wake_src, div_sel, ana_skew} = '0;
        {mode_wr, mode_req, usb_src, usb_ic_48} = '0;
        ic_en = 8'h01;
        bus_ratio = 16'h0002;
        div_ratio = {12{16'h0002}};
        act_tpl = 8'hFF;
        alt_tpl = 8'hFE;
        for (int i = 0; i < 7; i++) src_rank[i*3+:3] = 3'((i * 5 + 3) % 8);
        exp_mode = 0;
        cpu_off = 0;
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        chk_mode();
        act_tpl = 8'($urandom) | 8'h01;
        alt_tpl = 8'($urandom) & 8'hFE;
        step();
        chk_mode();
        cpu_off_req = 1;
        step();
        cpu_off_req = 0;
        cpu_off = 1;
        chk_mode();
        poke(6'h00, 1);
        set_mode(CDPM_ALT_ACTIVE);
        poke(6'h00, 1);
        for (int w = 0; w < 6; w++) begin
            set_mode(CDPM_SLEEP);
            chk("slow_clk_en", 1, slow_clk_en);
            chk("timewheel_en", 1, timewheel_en);
            poke(6'(1 << w), 0);
        end
        set_mode(CDPM_HIBERNATE);
        chk("slow_clk_en", 0, slow_clk_en);
        chk("timewheel_en", 0, timewheel_en);
        chk("cpu_clk", 0, cpu_clk);
        poke(~6'(1 << CDPM_WAKE_PIN), 1);
        poke(6'(1 << CDPM_WAKE_PIN), 0);
        act_tpl = 8'hFF;
        for (int k = 0; k < 4; k++) begin
            src_valid = 7'($urandom) | 7'h01;
            best = 0;
            for (int i = 0; i < 7; i++) begin
                if (src_valid[i] && (!src_valid[best] ||
                    src_rank[i*3+:3] > src_rank[best*3+:3])) best = i;
            end
            repeat (3) step();
            chk("sys_sel", 16'(best), sys_sel);
        end
        src_valid = 7'h7F;
        for (int u = 0; u < 4; u++) begin
            usb_src = 2'(u);
            usb_ic_48 = 1;
            repeat (3) step();
            chk("usb_clk_ok", 1, usb_clk_ok);
        end
        usb_src = 2'h0;
        usb_ic_48 = 0;
        repeat (3) step();
        chk("usb_clk_ok", 0, usb_clk_ok);
        foreach (ratios[j]) begin
            r = (ratios[j] < 2) ? 2 : ratios[j];
            bus_ratio = 16'(ratios[j]);
            repeat (40) step();
            cnt_edges(0, 240);
            // The bus divider counts a half-rate tick: period is 2r cycles.
            chk("bus_edges", 16'(240 / (2 * r)), 16'(e), 1);
            chk("bus_high", 16'(240 * ((r + 1) / 2) / r), 16'(h), r);
        end
        for (int g = 0; g < 12; g++) begin
            s = $urandom % 7;
            r = 2 + $urandom % 4;
            div_sel[g*3+:3] = 3'(s);
            div_ratio[g*16+:16] = 16'(r);
            if (g > 7) ana_skew[(g-8)*16+:16] = 16'($urandom % 4);
            repeat (100) step();
            cnt_edges(g + 1, 600);
            chk("div_edges", 16'(600 / (r * 2 * (s + 2))), 16'(e), 1);
        end
        div_sel[5:0] = 6'h3F;
        div_ratio[31:0] = {16'h0002, 16'h0002};
        repeat (100) step();
        cnt_edges(1, 480);
        chk("ic_edges", 16'd40, 16'(e), 1);
        cnt_edges(2, 480);
        chk("chain_edges", 16'd20, 16'(e), 1);
        results();
    end
endmodule : tb_top
